// *** sec_pkg.sv ***
// shared constants and types of the serial eeprom command link
// assumes both ends and the bench import it whole

package sec_pkg;

  // ---------------------------------------------------------------
  // field widths
  // ---------------------------------------------------------------
  localparam logic [4:0] HDR_BITS = 5'h03;  // start bit plus opcode
  localparam logic [4:0] ADDR_W16 = 5'h0a;
  localparam logic [4:0] ADDR_W8  = 5'h0b;
  localparam logic [4:0] DATA_W16 = 5'h10;
  localparam logic [4:0] DATA_W8  = 5'h08;

  // ---------------------------------------------------------------
  // opcodes and qualifiers of opcode 00
  // ---------------------------------------------------------------
  localparam logic [1:0] OP_EXT     = 2'h0;
  localparam logic [1:0] OP_WRITE   = 2'h1;
  localparam logic [1:0] OP_READ    = 2'h2;
  localparam logic [1:0] OP_ERASE   = 2'h3;
  localparam logic [1:0] SUB_LOCK   = 2'h0;
  localparam logic [1:0] SUB_FILL   = 2'h1;
  localparam logic [1:0] SUB_CLEAR  = 2'h2;
  localparam logic [1:0] SUB_UNLOCK = 2'h3;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int PROG_TIME_US  = 15000;
  localparam int PROG_CYCLES   = PROG_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int TMR_W         = 18;
  localparam int CS_LOW_NS     = 1000;
  localparam int CS_LOW_CYCLES =
    (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCLK_PERIOD_NS  = 4000;
  localparam int SCLK_HALF_CYCLES =
    (SCLK_PERIOD_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    CMD_READ   = 3'h0,
    CMD_WRITE  = 3'h1,
    CMD_ERASE  = 3'h2,
    CMD_UNLOCK = 3'h3,
    CMD_LOCK   = 3'h4,
    CMD_FILL   = 3'h5,
    CMD_CLEAR  = 3'h6
  } sec_cmd_t;

  typedef enum logic [2:0] {
    PS_IDLE = 3'h0,
    PS_OP   = 3'h1,
    PS_ADDR = 3'h2,
    PS_DATA = 3'h3,
    PS_READ = 3'h4,
    PS_DONE = 3'h5
  } sec_pst_t;

  typedef enum logic [2:0] {
    H_IDLE  = 3'h0,
    H_LOW   = 3'h1,
    H_HIGH  = 3'h2,
    H_DESEL = 3'h3,
    H_POLL  = 3'h4
  } sec_hst_t;

endpackage

// *** sec_if.sv ***
// pins of the serial eeprom link between master and device
// assumes the bench connects one master and one device

`timescale 1ns/1ns

interface sec_if;
  logic chip_select;
  logic serial_clock;
  logic serial_in;
  logic so_val;
  logic so_oe;
  logic ws_val;
  logic ws_oe;
  wire  serial_out;
  wire  width_select;

  // pulled-up lines: undriven output reads 1, open strap selects wide
  assign serial_out   = so_oe ? so_val : 1'b1;
  assign width_select = ws_oe ? ws_val : 1'b1;

  modport dev (
    input  chip_select,
    input  serial_clock,
    input  serial_in,
    input  width_select,
    output so_val,
    output so_oe
  );

  modport host (
    output chip_select,
    output serial_clock,
    output serial_in,
    output ws_val,
    output ws_oe,
    input  serial_out
  );
endinterface

// *** sec_dev.sv ***
// device end of the serial eeprom link: command decode and status
// assumes a memory array on mem_addr / mem_rdata and a programmer
// that acts on prog_start; serial_clock only runs while selected
//
// How it works
// - serial_in captured on rising serial_clock while selected
// - read data on serial_out changes on rising serial_clock edges
// - serial_out driven only while chip_select high
// - wide strap: 16-bit data, 10-bit address
// - open strap reads high, wide format
// - leading zeros skipped until a one
// - two-bit opcode follows start bit
// - full address for read, write, erase
// - write and fill carry trailing data word
// - data words move most significant bit first
// - master clocks every address bit, even don't-cares
// - transaction spans chip_select high to low
// - select fall launches timed programming, busy shown
// - read sends dummy zero then word
// - master may deselect after full read word
// - select rise restarts parser; idle while deselected
// - master holds select low for deselect time
// - starts locked; unlock and lock commands toggle
// - while programming and selected, 0 busy, 1 ready

`timescale 1ns/1ns

module sec_dev
  import sec_pkg::*;
#(
  parameter int PROG_CYC = PROG_CYCLES
) (
  input  wire logic       clk,
  input  wire logic       rst,
  sec_if.dev              bus,
  output logic     [10:0] mem_addr,
  input  wire logic [15:0] mem_rdata,
  output logic            prog_start,
  output sec_cmd_t        prog_kind,
  output logic     [10:0] prog_addr,
  output logic     [15:0] prog_data,
  output logic            busy,
  output logic            write_en
);

  // ---------------------------------------------------------------
  // state: parser (link clock, cleared while deselected),
  // command hold (link clock), launch and timer (system clock)
  // ---------------------------------------------------------------
  typedef struct packed {
    sec_pst_t    st;
    logic [4:0]  cnt;
    logic [1:0]  opc;
    logic [10:0] sr;
    logic [15:0] dsr;
    logic        drv;
    logic        dbit;
    logic [15:0] rsh;
  } sec_prs_t;

  typedef struct packed {
    logic        nws1;
    logic        nws2;
    sec_cmd_t    kind;
    logic [10:0] addr;
    logic [15:0] data;
    logic        tog;
    logic        clr;
  } sec_hold_t;

  typedef struct packed {
    logic             cs1;
    logic             cs2;
    logic             cs3;
    logic             tg1;
    logic             tg2;
    logic             seen;
    logic             cl1;
    logic             cl2;
    logic             cl3;
    logic             unlk;
    logic             busy;
    logic             stat;
    logic [TMR_W-1:0] tmr;
    logic             start;
    sec_cmd_t         kind;
    logic [10:0]      addr;
    logic [15:0]      data;
  } sec_sys_t;

  sec_prs_t  p_q, p_d;
  sec_hold_t h_q, h_d;
  sec_sys_t  k_q, k_d;
  logic      prs_arst;
  logic      wide;
  logic      din;
  logic [4:0]  alen;
  logic [4:0]  dlen;
  logic [10:0] full;
  logic [1:0]  qual;
  logic [15:0] src;
  sec_cmd_t    kind;

  // low select holds the parser cleared, so a rise starts afresh
  assign prs_arst = rst | ~bus.chip_select;

  // ---------------------------------------------------------------
  // link side decode
  // ---------------------------------------------------------------
  always_comb begin
    p_d      = p_q;
    h_d      = h_q;
    h_d.nws1 = ~bus.width_select;
    h_d.nws2 = h_q.nws1;
    wide     = ~h_q.nws2;
    din      = bus.serial_in;
    alen     = wide ? ADDR_W16 : ADDR_W8;
    dlen     = wide ? DATA_W16 : DATA_W8;
    full     = {p_q.sr[9:0], din};
    // don't-care bits still shift in, only the top two qualify
    qual     = wide ? full[9:8] : full[10:9];
    src      = wide ? mem_rdata : {mem_rdata[7:0], 8'h00};
    kind     = CMD_READ;
    unique case (p_q.opc)
      OP_READ:  kind = CMD_READ;
      OP_WRITE: kind = CMD_WRITE;
      OP_ERASE: kind = CMD_ERASE;
      OP_EXT: begin
        unique case (qual)
          SUB_UNLOCK: kind = CMD_UNLOCK;
          SUB_FILL:   kind = CMD_FILL;
          SUB_LOCK:   kind = CMD_LOCK;
          SUB_CLEAR:  kind = CMD_CLEAR;
        endcase
      end
    endcase
    unique case (p_q.st)
      PS_IDLE: begin
        if (din) begin
          p_d.st  = PS_OP;
          p_d.cnt = 5'h00;
          h_d.clr = ~h_q.clr;
        end
      end
      PS_OP: begin
        p_d.opc = {p_q.opc[0], din};
        p_d.cnt = p_q.cnt + 5'h01;
        if (p_q.cnt == 5'h01) begin
          p_d.st  = PS_ADDR;
          p_d.cnt = 5'h00;
        end
      end
      PS_ADDR: begin
        p_d.sr  = full;
        p_d.cnt = p_q.cnt + 5'h01;
        if (p_q.cnt == alen - 5'h01) begin
          h_d.kind = kind;
          h_d.addr = full;
          p_d.cnt  = 5'h00;
          if (kind == CMD_READ) begin
            p_d.st   = PS_READ;
            p_d.drv  = 1'b1;
            p_d.dbit = 1'b0;
          end else if (kind == CMD_WRITE || kind == CMD_FILL) begin
            p_d.st = PS_DATA;
          end else begin
            p_d.st  = PS_DONE;
            h_d.tog = ~h_q.tog;
          end
        end
      end
      PS_DATA: begin
        p_d.dsr = {p_q.dsr[14:0], din};
        p_d.cnt = p_q.cnt + 5'h01;
        if (p_q.cnt == dlen - 5'h01) begin
          h_d.data = wide ? {p_q.dsr[14:0], din}
                          : {8'h00, p_q.dsr[6:0], din};
          h_d.tog  = ~h_q.tog;
          p_d.st   = PS_DONE;
        end
      end
      PS_READ: begin
        // the dummy bit gives the array one clock to answer
        if (p_q.cnt == 5'h00) begin
          p_d.cnt  = 5'h01;
          p_d.dbit = src[15];
          p_d.rsh  = {src[14:0], 1'b0};
        end else begin
          p_d.dbit = p_q.rsh[15];
          p_d.rsh  = {p_q.rsh[14:0], 1'b0};
        end
      end
      PS_DONE: p_d = p_q;
      default: p_d.st = PS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // launch at select fall, self-timed programming
  // ---------------------------------------------------------------
  always_comb begin
    k_d       = k_q;
    k_d.cs1   = bus.chip_select;
    k_d.cs2   = k_q.cs1;
    k_d.cs3   = k_q.cs2;
    k_d.tg1   = h_q.tog;
    k_d.tg2   = k_q.tg1;
    k_d.cl1   = h_q.clr;
    k_d.cl2   = k_q.cl1;
    k_d.cl3   = k_q.cl2;
    k_d.start = 1'b0;
    if (k_q.busy) begin
      if (k_q.tmr == '0) begin
        k_d.busy = 1'b0;
      end else begin
        k_d.tmr = k_q.tmr - 1'b1;
      end
    end
    // a start bit after ready hides the status again
    if ((k_q.cl2 != k_q.cl3) && !k_q.busy) begin
      k_d.stat = 1'b0;
    end
    // hold registers are quiet once select is low, so the
    // synchronised fall qualifies them for the other clock
    if (k_q.cs3 && !k_q.cs2 && (k_q.tg2 != k_q.seen)) begin
      k_d.seen = k_q.tg2;
      unique case (h_q.kind)
        CMD_UNLOCK: k_d.unlk = 1'b1;
        CMD_LOCK:   k_d.unlk = 1'b0;
        CMD_READ:   k_d.unlk = k_q.unlk;
        default: begin
          // locked or already busy: the command is dropped
          if (k_q.unlk && !k_q.busy) begin
            k_d.busy  = 1'b1;
            k_d.stat  = 1'b1;
            k_d.tmr   = TMR_W'(PROG_CYC - 1);
            k_d.start = 1'b1;
            k_d.kind  = h_q.kind;
            k_d.addr  = h_q.addr;
            k_d.data  = h_q.data;
          end
        end
      endcase
    end
  end

  always_ff @(posedge bus.serial_clock or posedge prs_arst) begin
    if (prs_arst) begin
      p_q <= '0;
    end else begin
      p_q <= p_d;
    end
  end

  always_ff @(posedge bus.serial_clock or posedge rst) begin
    if (rst) begin
      h_q <= '0;
    end else begin
      h_q <= h_d;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      k_q <= '0;
    end else begin
      k_q <= k_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  // status must show with no link clock, so the pin mixes both
  // domains and select gates the enable directly
  assign bus.so_oe  = bus.chip_select & (p_q.drv | k_q.stat);
  assign bus.so_val = p_q.drv ? p_q.dbit : ~k_q.busy;
  assign mem_addr   = h_q.addr;
  assign prog_start = k_q.start;
  assign prog_kind  = k_q.kind;
  assign prog_addr  = k_q.addr;
  assign prog_data  = k_q.data;
  assign busy       = k_q.busy;
  assign write_en   = k_q.unlk;

endmodule // sec_dev

// *** sec_host.sv ***
// master end of the serial eeprom link
// assumes one request at a time from user logic on clk

`timescale 1ns/1ns

module sec_host
  import sec_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst,
  sec_if.host              bus,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire sec_cmd_t    req_kind,
  input  wire logic [10:0] req_addr,
  input  wire logic [15:0] req_data,
  input  wire logic        strap_drive,
  input  wire logic        strap_level,
  output logic             rsp_valid,
  output logic [15:0]      rsp_data
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    sec_hst_t    st;
    logic [4:0]  ph;
    logic [5:0]  bits;
    logic [31:0] sh;
    logic [15:0] rd;
    logic        cs;
    logic        sclk;
    logic        sdat;
    logic        prog;
    logic        fin;
    logic        wide;
    logic        ready;
    logic        rvld;
    logic [15:0] rdat;
    logic        wsv;
    logic        wso;
    logic        do1;
    logic        do2;
  } sec_hstate_t;

  sec_hstate_t q, d;
  logic [1:0]  op;
  logic [1:0]  ql;
  logic        ext;
  logic        hd;
  logic        rdk;
  logic        wd;
  logic [9:0]  a10;
  logic [10:0] a11;
  logic [31:0] vec;
  logic [5:0]  nb;

  // ---------------------------------------------------------------
  // frame build and bit sequencing
  // ---------------------------------------------------------------
  always_comb begin
    d      = q;
    d.do1  = bus.serial_out;
    d.do2  = q.do1;
    d.wsv  = strap_level;
    d.wso  = strap_drive;
    d.rvld = 1'b0;
    op     = OP_EXT;
    ql     = SUB_LOCK;
    hd     = 1'b0;
    unique case (req_kind)
      CMD_READ:   op = OP_READ;
      CMD_WRITE: begin
        op = OP_WRITE;
        hd = 1'b1;
      end
      CMD_ERASE:  op = OP_ERASE;
      CMD_UNLOCK: ql = SUB_UNLOCK;
      CMD_FILL: begin
        ql = SUB_FILL;
        hd = 1'b1;
      end
      CMD_CLEAR:  ql = SUB_CLEAR;
      default:    ql = SUB_LOCK;
    endcase
    ext = (op == OP_EXT);
    rdk = (req_kind == CMD_READ);
    wd  = ~strap_drive | strap_level;
    // don't-care address bits are still sent, as zeros
    a10 = ext ? {ql, 8'h00} : req_addr[9:0];
    a11 = ext ? {ql, 9'h000} : req_addr;
    vec = wd ? {1'b1, op, a10, req_data, 3'h0}
             : {1'b1, op, a11, req_data[7:0], 10'h000};
    nb  = {1'b0, HDR_BITS} + {1'b0, wd ? ADDR_W16 : ADDR_W8}
        + ((hd | rdk) ? {1'b0, wd ? DATA_W16 : DATA_W8} : 6'h00);
    unique case (q.st)
      H_IDLE: begin
        d.ready = 1'b1;
        if (req_valid && q.ready) begin
          d.ready = 1'b0;
          d.wide  = wd;
          d.sh    = vec;
          d.bits  = nb;
          d.prog  = ~rdk & (hd | (req_kind == CMD_ERASE)
                    | (req_kind == CMD_CLEAR));
          d.fin   = 1'b0;
          d.cs    = 1'b1;
          d.sdat  = vec[31];
          d.ph    = 5'h00;
          d.st    = H_LOW;
        end
      end
      H_LOW: begin
        d.ph = q.ph + 5'h01;
        if (q.ph == 5'(SCLK_HALF_CYCLES - 1)) begin
          d.ph   = 5'h00;
          d.sclk = 1'b1;
          d.st = H_HIGH;
        end
      end
      H_HIGH: begin
        d.ph = q.ph + 5'h01;
        if (q.ph == 5'(SCLK_HALF_CYCLES - 1)) begin
          d.ph   = 5'h00;
          d.sclk = 1'b0;
          d.rd   = {q.rd[14:0], q.do2};
          d.sh   = {q.sh[30:0], 1'b0};
          d.sdat = q.sh[30];
          d.bits = q.bits - 6'h01;
          d.st   = H_LOW;
          if (q.bits == 6'h01) begin
            d.cs = 1'b0;
            d.sdat = 1'b0;
            d.st = H_DESEL;
          end
        end
      end
      H_DESEL: begin
        d.ph = q.ph + 5'h01;
        if (q.ph == 5'(CS_LOW_CYCLES - 1)) begin
          d.ph = 5'h00;
          if (q.prog && !q.fin) begin
            d.cs = 1'b1;
            d.st = H_POLL;
          end else begin
            d.rvld  = 1'b1;
            d.rdat  = q.wide ? q.rd : {8'h00, q.rd[7:0]};
            d.ready = 1'b1;
            d.st    = H_IDLE;
          end
        end
      end
      H_POLL: begin
        d.ph = q.ph + 5'h01;
        if (q.ph == 5'(SCLK_HALF_CYCLES - 1)) begin
          d.ph = 5'h00;
          if (q.do2) begin
            // one start bit clears the ready display
            d.sh   = 32'h80000000;
            d.sdat = 1'b1;
            d.bits = 6'h01;
            d.fin  = 1'b1;
            d.st   = H_LOW;
          end else begin
            d.cs = 1'b0;
            d.st = H_DESEL;
          end
        end
      end
      default: d.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign bus.chip_select  = q.cs;
  assign bus.serial_clock = q.sclk;
  assign bus.serial_in    = q.sdat;
  assign bus.ws_val       = q.wsv;
  assign bus.ws_oe        = q.wso;
  assign req_ready        = q.ready;
  assign rsp_valid        = q.rvld;
  assign rsp_data         = q.rdat;

endmodule // sec_host

// *** sec_link_checker.sv ***
// concurrent checks on the pins of the serial eeprom link
// assumes the bench places it beside the link interface, clk domain

`timescale 1ns/1ns

module sec_link_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic chip_select,
  input wire logic serial_clock,
  input wire logic serial_in,
  input wire logic so_val,
  input wire logic so_oe,
  input wire logic ws_oe,
  input wire logic width_select
);
  // ---------------------------------------------------------------
  // cycles since select fell, saturating so long gaps stay legal
  // ---------------------------------------------------------------
  logic [3:0] low_cnt_q;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      low_cnt_q <= 4'hf;
    end else if (chip_select) begin
      low_cnt_q <= 4'h0;
    end else if (low_cnt_q != 4'hf) begin
      low_cnt_q <= low_cnt_q + 4'h1;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  a_out_needs_select: assert property (
    so_oe |-> chip_select)
    else $error("serial_out driven while deselected");
  // device read data changes on the rise itself, so look mid-phase only
  a_out_steady_high: assert property (
    so_oe && $past(so_oe) && serial_clock && $past(serial_clock, 8)
    |-> $stable(so_val))
    else $error("serial_out moved away from a clock rise");
  a_clock_idle_desel: assert property (
    !chip_select |-> !serial_clock)
    else $error("serial clock runs while deselected");
  a_desel_gap: assert property (
    $rose(chip_select) |-> low_cnt_q >= 4'ha)
    else $error("select low time too short");
  a_clock_half_period: assert property (
    $rose(serial_clock) |-> ##20 $fell(serial_clock))
    else $error("serial clock high phase not 20 cycles");
  a_din_held_high: assert property (
    serial_clock && $past(serial_clock) |-> $stable(serial_in))
    else $error("serial_in changed while clock high");
  a_strap_default: assert property (
    !ws_oe |-> width_select)
    else $error("open strap does not read wide");
  a_cs_setup_low: assert property (
    $rose(chip_select) |-> !serial_clock [*8])
    else $error("clock rose too soon after select");
endmodule // sec_link_checker

// *** serial_eeprom_command_interface_bench.sv ***
// bench for both link ends joined through sec_if
// assumes sec_pkg, sec_if, sec_host, sec_dev; word store is modelled

`timescale 1ns/1ns

module serial_eeprom_command_interface_bench;
  import sec_pkg::*;

  logic        clk;
  logic        rst;
  logic        req_valid;
  logic        req_ready;
  sec_cmd_t    req_kind;
  logic [10:0] req_addr;
  logic [15:0] req_data;
  logic        strap_drive;
  logic        strap_level;
  logic        busy_seen;
  logic        rsp_valid;
  logic [15:0] rsp_data;
  logic [10:0] mem_addr;
  logic [15:0] mem_rdata;
  logic        prog_start;
  sec_cmd_t    prog_kind;
  logic [10:0] prog_addr;
  logic [15:0] prog_data;
  logic        busy;
  logic        write_en;
  int          fails;
  int          n_checks;
  int          n_prog;
  int          n_bits;
  int          n_busy;
  int          hi_cnt;
  int          cs_cnt;
  int          p;
  int          b;
  logic [31:0] in_sh;
  logic [31:0] out_sh;
  sec_cmd_t    k_tab [4] = '{CMD_WRITE, CMD_FILL, CMD_ERASE, CMD_CLEAR};
  logic [10:0] a_tab [4] = '{11'h2aa, 11'h000, 11'h3ff, 11'h000};
  logic [15:0] d_tab [4] = '{16'hbeef, 16'h1234, 16'h0000, 16'h0000};
  logic [31:0] h_tab [4] = '{32'h16, 32'h11, 32'h1f, 32'h12};

  sec_if link ();

  sec_host u_sec_host (
    .clk       (clk),
    .rst       (rst),
    .bus       (link),
    .req_valid (req_valid),
    .req_ready (req_ready),
    .req_kind  (req_kind),
    .req_addr  (req_addr),
    .req_data  (req_data),
    .strap_drive (strap_drive),
    .strap_level (strap_level),
    .rsp_valid (rsp_valid),
    .rsp_data  (rsp_data)
  );

  sec_dev #(.PROG_CYC(50)) u_sec_dev (
    .clk        (clk),
    .rst        (rst),
    .bus        (link),
    .mem_addr   (mem_addr),
    .mem_rdata  (mem_rdata),
    .prog_start (prog_start),
    .prog_kind  (prog_kind),
    .prog_addr  (prog_addr),
    .prog_data  (prog_data),
    .busy       (busy),
    .write_en   (write_en)
  );

  sec_link_checker u_sec_link_checker (
    .clk          (clk),
    .rst          (rst),
    .chip_select  (link.chip_select),
    .serial_clock (link.serial_clock),
    .serial_in    (link.serial_in),
    .so_val       (link.so_val),
    .so_oe        (link.so_oe),
    .ws_oe        (link.ws_oe),
    .width_select (link.width_select)
  );

  // word store: a fixed pattern per address keeps expectations simple
  assign mem_rdata = 16'hc3a5 ^ {5'h00, mem_addr};

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------------------------
  // comparison, closing and request tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic do_req(input sec_cmd_t k, input logic [10:0] a,
                        input logic [15:0] d);
    int i;
    for (i = 0; i < 100 && req_ready !== 1'b1; i++) @(negedge clk);
    if (i < 100) begin
      n_bits = 0;
      in_sh = 32'h0;
      out_sh = 32'h0;
      busy_seen = 1'b0;
      req_valid = 1'b1;
      req_kind = k;
      req_addr = a;
      req_data = d;
      @(negedge clk);
      req_valid = 1'b0;
      for (i = 0; i < 20000 && rsp_valid !== 1'b1; i++) @(negedge clk);
    end else begin
      // host never became ready: treat as a timed-out request
      i = 20000;
    end
    if (i == 20000) begin
      fails++;
      finish_test();
    end
    $display("test %s done", k.name());
  endtask

  // ---------------------------------------------------------------
  // wire watcher: bits mid high phase, status while polling
  // ---------------------------------------------------------------
  always @(negedge clk) begin
    if (prog_start === 1'b1) n_prog++;
    hi_cnt = link.serial_clock ? hi_cnt + 1 : 0;
    cs_cnt = link.chip_select ? cs_cnt + 1 : 0;
    if (hi_cnt == 10 && link.chip_select) begin
      in_sh = {in_sh[30:0], link.serial_in};
      out_sh = {out_sh[30:0], link.serial_out};
      n_bits++;
    end
    if (cs_cnt > 5 && !link.serial_clock && busy === 1'b1) begin
      n_busy++;
      chk({31'h0, link.serial_out}, 32'h0);
    end
    // once programming ends the polled status must read ready
    if (cs_cnt > 5 && !link.serial_clock && busy === 1'b0
        && busy_seen) begin
      chk({31'h0, link.serial_out}, 32'h1);
    end
    if (busy === 1'b1) busy_seen = 1'b1;
  end

  initial begin
    rst = 1'b1;
    req_valid = 1'b0;
    req_kind = CMD_READ;
    req_addr = 11'h000;
    req_data = 16'h0000;
    strap_drive = 1'b0;
    strap_level = 1'b1;
    busy_seen = 1'b0;
    {fails, n_checks, n_prog, n_bits, n_busy, hi_cnt, cs_cnt} = '0;
    in_sh = 32'h0;
    out_sh = 32'h0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    do_req(CMD_READ, 11'h155, 16'h0000);
    chk({16'h0, rsp_data}, 32'hc2f0);
    chk(in_sh >> 16, 32'h1955);
    chk(out_sh & 32'h1ffff, 32'h0c2f0);
    chk({21'h0, mem_addr}, 32'h155);
    p = n_prog;
    do_req(CMD_WRITE, 11'h2aa, 16'hbeef);
    chk(32'(n_prog - p), 32'h0);
    do_req(CMD_UNLOCK, 11'h000, 16'h0000);
    chk({31'h0, write_en}, 32'h1);
    chk(in_sh >> 8, 32'h13);
    for (int t = 0; t < 4; t++) begin
      p = n_prog;
      b = n_busy;
      do_req(k_tab[t], a_tab[t], d_tab[t]);
      chk(32'(n_prog - p), 32'h1);
      chk({29'h0, prog_kind}, {29'h0, k_tab[t]});
      chk(in_sh >> (n_bits - 5), h_tab[t]);
      chk({31'h0, n_busy > b}, 32'h1);
      chk({31'h0, busy}, 32'h0);
      if (t < 2) chk({16'h0, prog_data}, {16'h0, d_tab[t]});
      if (t % 2 == 0) chk({21'h0, prog_addr}, {21'h0, a_tab[t]});
    end
    do_req(CMD_LOCK, 11'h000, 16'h0000);
    chk({31'h0, write_en}, 32'h0);
    p = n_prog;
    do_req(CMD_ERASE, 11'h001, 16'h0000);
    chk(32'(n_prog - p), 32'h0);
    // narrow strap; first transfer lets the strap settle at the device
    strap_drive = 1'b1;
    strap_level = 1'b0;
    do_req(CMD_LOCK, 11'h000, 16'h0000);
    do_req(CMD_READ, 11'h7ff, 16'h0000);
    chk({16'h0, rsp_data}, 32'h005a);
    chk(in_sh >> 8, 32'h37ff);
    chk(out_sh & 32'h1ff, 32'h05a);
    do_req(CMD_UNLOCK, 11'h000, 16'h0000);
    do_req(CMD_WRITE, 11'h4a5, 16'h00c3);
    chk({21'h0, prog_addr}, 32'h4a5);
    chk({24'h0, prog_data[7:0]}, 32'hc3);
    chk(in_sh >> (n_bits - 5), 32'h16);
    finish_test();
  end
endmodule // serial_eeprom_command_interface_bench
